// ===== rtl/adcrr_params.svh
/*
   Register indices, field positions, reset values and conversion timing of
   the converter result readout. Assumes inclusion by bare name, once per unit.
*/
`ifndef ADCRR_PARAMS_SVH
`define ADCRR_PARAMS_SVH

// ****************************************************************
// Register map: indices; byte address is four times the index
// ****************************************************************
`define ADCRR_AW          14
`define ADCRR_IDX_CTRL    12'hf70
`define ADCRR_IDX_UPPER   12'hf72
`define ADCRR_IDX_LOWER   12'hf73

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ADCRR_CEN_BIT     7
`define ADCRR_CONTINUOUS_SELECT_BIT    4
`define ADCRR_RES_W       13
`define ADCRR_HI_LSB      5
`define ADCRR_TEMP_SEL    4'he
`define ADCRR_CTRL_RST    8'h00

// ****************************************************************
// Conversion timing in system clock cycles
// ****************************************************************
`define ADCRR_INIT_CYC    5129
`define ADCRR_CONTINUOUS_SELECT_CYC    256

`endif

// ===== rtl/adcrr_pkg.sv
/*
   Types shared by the converter result readout modules.
   Assumes adcrr_params.svh is on the include path.
*/
`include "adcrr_params.svh"

package adcrr_pkg;

   typedef enum logic [1:0] {T_IDLE, T_FIRST, T_REP} adcrr_tst_t;

   typedef struct packed {
      adcrr_tst_t  state;
      logic [14:0] cnt;
      logic        dbl;
      logic        done;
      logic        done_rep;
   } adcrr_tmr_t;

   typedef struct packed {
      logic                    conversion_enable;
      logic                    continuous_select;
      logic [3:0]              sel;
      logic                    start;
      logic [`ADCRR_RES_W-1:0] result;
      logic                    res_ovf;
      logic [4:0]              low_lat;
      logic                    ovf_lat;
      logic                    pend;
      logic                    dp_wr;
      logic                    dp_ctrl;
      logic                    dp_ro;
      logic [31:0]             hrdata;
   } adcrr_top_t;

endpackage

// ===== rtl/adcrr_buf.sv
/*
   Small FIFO of DEPTH words of W bits with valid and ready on both sides.
   Assumes DEPTH is a power of two and both sides run on hclk.
*/
`timescale 1ns/100ps

module adcrr_buf
#(
   parameter int W     = 14,
   parameter int DEPTH = 2
)
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output      logic         in_ready,
   output      logic         out_valid,
   output      logic [W-1:0] out_data,
   input  wire logic         out_ready
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [PW:0]             cnt;
      logic                    full;
      logic                    empty;
   } adcrr_buf_t;

   adcrr_buf_t s;
   adcrr_buf_t next_s;
   logic       push;
   logic       pop;

   assign in_ready  = !s.full;
   assign out_valid = !s.empty;
   assign out_data  = s.mem[s.rp];
   assign push      = in_valid && !s.full;
   assign pop       = out_ready && !s.empty;

   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.mem[s.wp] = in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop)
      begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt   = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
      next_s.full  = (next_s.cnt == (PW+1)'(DEPTH));
      next_s.empty = (next_s.cnt == '0);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s       <= '0;
         s.empty <= 1'b1;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

endmodule

// ===== rtl/adcrr_timer.sv
/*
   Conversion timer: a first conversion, then repeats while continuous mode
   is selected; temperature measurements take twice as long.
   Assumes start is a one-cycle pulse on hclk.
*/
`timescale 1ns/100ps

module adcrr_timer
   import adcrr_pkg::*;
#(
   parameter int INIT_CYC = `ADCRR_INIT_CYC,
   parameter int CONTINUOUS_SELECT_CYC = `ADCRR_CONTINUOUS_SELECT_CYC
)
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ce,
   input  wire logic start,
   input  wire logic continuous_select,
   input  wire logic temp,
   output      logic done,
   output      logic busy
);

   adcrr_tmr_t  s;
   adcrr_tmr_t  next_s;
   logic [14:0] gap;

   function automatic logic [14:0] load(input int c, input logic d);
      load = 15'(d ? 2 * c - 1 : c - 1);
   endfunction

   assign done = s.done;
   assign busy = (s.state != T_IDLE);

   always_comb
   begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start)
      begin
         next_s.state = T_FIRST;
         next_s.dbl   = temp;
         next_s.cnt   = load(INIT_CYC, temp);
      end
      else
      begin
         unique case (s.state)
            T_IDLE:
            begin
               next_s.cnt = s.cnt;
            end
            T_FIRST, T_REP:
            begin
               if (s.cnt == '0)
               begin
                  next_s.done     = 1'b1;
                  next_s.done_rep = (s.state == T_REP);
                  if (continuous_select)
                  begin
                     next_s.state = T_REP;
                     next_s.cnt   = load(CONTINUOUS_SELECT_CYC, s.dbl);
                  end
                  else
                  begin
                     next_s.state = T_IDLE;
                  end
               end
               else
               begin
                  next_s.cnt = s.cnt - 15'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // Cycles since the last completion, read only by the check below.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gap <= '0;
      end
      else if (ce)
      begin
         gap <= s.done ? 15'h0001 : gap + 15'h0001;
      end
   end

   a_repeat_gap: assert property (@(posedge hclk) disable iff (!hresetn)
      s.done && s.done_rep |-> gap == load(CONTINUOUS_SELECT_CYC, s.dbl) + 15'h0001)
      else $error("continuous refresh period wrong");

endmodule

// ===== rtl/adcrr_top.sv
/*
   Converter result readout: AHB-Lite register slave holding the control
   bits, the result registers with upper-read snapshot, a two-entry sample
   buffer and the conversion timer.
   Assumes the converter core runs on hclk and hands over one sample with
   its overflow flag per completed conversion.
*/
// Our own choice: the AHB-Lite slave port.
// What this block does
// - Result is a 13-bit two's complement value split over two registers.
// - Upper-byte register returns result bits 12 down to 5.
// - Reading the upper byte snapshots the lower bits of the same sample.
// - Lower-bits register holds result bits 4 down to 0 in bits 7:3.
// - Bit 0 of lower-bits register flags a sample with hardware overflow.
// - Results are invalid while a single-shot conversion runs.
// - In continuous mode the newest completed conversion is held.
// - Result bits are undefined after reset until a conversion completes.
// - Bits 2 and 1 of lower-bits register are reserved.
// - Both result registers are read-only; writes change nothing.
// - Conversion enable clears itself when a conversion finishes.
// - Continuous refresh every 256 cycles after 5129; temperature doubles.
`timescale 1ns/100ps

module adcrr_top
   import adcrr_pkg::*;
#(
   parameter int INIT_CYC = `ADCRR_INIT_CYC,
   parameter int CONTINUOUS_SELECT_CYC = `ADCRR_CONTINUOUS_SELECT_CYC
)
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    ce,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output      logic                    hreadyout,
   output      logic                    hresp,
   output      logic [31:0]             hrdata,
   input  wire logic                    core_valid,
   input  wire logic [`ADCRR_RES_W-1:0] core_data,
   input  wire logic                    core_ovf,
   output      logic                    core_ready,
   output      logic                    conv_run,
   output      logic [3:0]              conv_input
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   adcrr_top_t                s;
   adcrr_top_t                next_s;
   logic                      acc;
   logic                      rd_upper;
   logic                      rd_lower;
   logic                      rd_ctrl;
   logic                      wr_cen;
   logic                      drain;
   logic                      done;
   logic                      busy;
   logic                      buf_valid;
   logic [`ADCRR_RES_W:0]     buf_data;

   function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
      hit = (a[`ADCRR_AW-1:0] == {idx, 2'b00});
   endfunction

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   assign acc      = hsel && htrans[1] && hready;
   assign rd_upper = acc && !hwrite && hit(haddr, `ADCRR_IDX_UPPER);
   assign rd_lower = acc && !hwrite && hit(haddr, `ADCRR_IDX_LOWER);
   assign rd_ctrl  = acc && !hwrite && hit(haddr, `ADCRR_IDX_CTRL);
   assign wr_cen   = s.dp_wr && s.dp_ctrl && hwdata[`ADCRR_CEN_BIT];

   // The result only takes a buffered sample after a completion and never
   // in the cycle of an upper-byte read, so the two halves always match.
   assign drain    = s.pend && buf_valid && !rd_upper;

   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = s.hrdata;
   assign conv_run   = busy;
   assign conv_input = s.sel;

   // ****************************************************************
   // Sample buffer and conversion timer
   // ****************************************************************
   adcrr_buf #(
      .W     (`ADCRR_RES_W + 1),
      .DEPTH (2)
   ) u_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .in_valid  (core_valid),
      .in_data   ({core_data, core_ovf}),
      .in_ready  (core_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (drain)
   );

   adcrr_timer #(
      .INIT_CYC (INIT_CYC),
      .CONTINUOUS_SELECT_CYC (CONTINUOUS_SELECT_CYC)
   ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .start   (s.start),
      .continuous_select    (s.continuous_select),
      .temp    (s.sel == `ADCRR_TEMP_SEL),
      .done    (done),
      .busy    (busy)
   );

   // ****************************************************************
   // Register and result logic
   // ****************************************************************
   always_comb
   begin
      next_s       = s;
      next_s.start = 1'b0;

      // Address phase: prepare read data, remember write targets.
      next_s.dp_wr   = acc && hwrite;
      next_s.dp_ctrl = hit(haddr, `ADCRR_IDX_CTRL);
      next_s.dp_ro   = hit(haddr, `ADCRR_IDX_UPPER) || hit(haddr, `ADCRR_IDX_LOWER);
      if (acc && !hwrite)
      begin
         next_s.hrdata = 32'h0000_0000;
      end
      if (rd_ctrl)
      begin
         // Enable reads back as one from the start write until the next completion.
         next_s.hrdata = {24'h00_0000, s.conversion_enable, 2'b00, s.continuous_select, s.sel};
      end
      if (rd_upper)
      begin
         next_s.hrdata  = {24'h00_0000, s.result[`ADCRR_RES_W-1:`ADCRR_HI_LSB]};
         next_s.low_lat = s.result[`ADCRR_HI_LSB-1:0];
         next_s.ovf_lat = s.res_ovf;
      end
      if (rd_lower)
      begin
         next_s.hrdata = {24'h00_0000, s.low_lat, 2'b00, s.ovf_lat};
      end

      // Data phase: only the control register takes writes.
      if (s.dp_wr && s.dp_ctrl)
      begin
         next_s.continuous_select = hwdata[`ADCRR_CONTINUOUS_SELECT_BIT];
         next_s.sel  = hwdata[3:0];
      end

      // Completion clears the enable; a simultaneous start write wins.
      if (done)
      begin
         next_s.conversion_enable = 1'b0;
      end
      if (wr_cen)
      begin
         next_s.conversion_enable   = 1'b1;
         next_s.start = 1'b1;
      end

      // A completed conversion moves the oldest buffered sample in.
      if (drain)
      begin
         next_s.result  = buf_data[`ADCRR_RES_W:1];
         next_s.res_ovf = buf_data[0];
         next_s.pend    = 1'b0;
      end
      if (done)
      begin
         next_s.pend = 1'b1;
      end
   end

   // Result fields are cleared at reset only for determinism; software
   // must treat them as undefined until the first completion.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s     <= '0;
         s.conversion_enable <= 1'(`ADCRR_CTRL_RST >> `ADCRR_CEN_BIT);
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge hclk);
   endclocking

   default disable iff (!hresetn);

   a_upper_read_data: assert property (
      ce && rd_upper |=> hrdata[7:0] == $past(s.result[12:5]) && hrdata[31:8] == 24'h00_0000)
      else $error("upper byte read data wrong");

   a_lower_snapshot: assert property (
      ce && rd_upper |=> s.low_lat == $past(s.result[4:0]))
      else $error("lower bits not captured on upper read");

   a_ovf_snapshot: assert property (
      ce && rd_upper |=> s.ovf_lat == $past(s.res_ovf))
      else $error("overflow flag not captured on upper read");

   a_snapshot_hold: assert property (
      !(ce && rd_upper) |=> $stable(s.low_lat) && $stable(s.ovf_lat))
      else $error("snapshot changed without upper read");

   a_lower_format: assert property (
      ce && rd_lower |=> hrdata[7:3] == $past(s.low_lat) && hrdata[2:1] == 2'b00
                         && hrdata[0] == $past(s.ovf_lat))
      else $error("lower bits read layout wrong");

   a_result_ro: assert property (
      s.dp_wr && s.dp_ro && !drain |=> $stable(s.result) && $stable(s.res_ovf))
      else $error("write altered a result register");

   a_cen_autoclear: assert property (
      ce && done && !wr_cen |=> !s.conversion_enable)
      else $error("enable not cleared at completion");

   a_result_update: assert property (
      ce && drain |=> s.result == $past(buf_data[13:1]) && s.pend == $past(done)
                      ##0 s.res_ovf == $past(buf_data[0]))
      else $error("result not refreshed from completed sample");

   a_start_busy: assert property (
      ce && wr_cen |=> s.conversion_enable && s.start ##1 (!$past(ce) || busy))
      else $error("start write did not begin a conversion");

   a_ctrl_read_data: assert property (
      ce && rd_ctrl
      |=> hrdata == {24'h00_0000, $past(s.conversion_enable), 2'b00, $past(s.continuous_select), $past(s.sel)})
      else $error("control read data wrong");

   a_lower_high_zero: assert property (
      ce && rd_lower
      |=> hrdata[31:8] == 24'h00_0000)
      else $error("lower bits read has upper bits set");

   a_unmapped_zero: assert property (
      ce && acc && !hwrite && !rd_upper && !rd_lower && !rd_ctrl
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_hrdata_hold: assert property (
      !(ce && acc && !hwrite)
      |=> $stable(hrdata))
      else $error("read data changed without a read");

   a_cen_hold: assert property (
      !done && !wr_cen
      |=> $stable(s.conversion_enable))
      else $error("enable changed without cause");

   a_cen_set: assert property (
      ce && wr_cen
      |=> s.conversion_enable)
      else $error("enable not set by write");

   a_start_clear: assert property (
      ce && !wr_cen
      |=> !s.start)
      else $error("start pulse without enable write");

   a_result_only_drain: assert property (
      !(ce && drain)
      |=> $stable(s.result) && $stable(s.res_ovf))
      else $error("result changed without a completed sample");

   a_upper_blocks_drain: assert property (
      ce && rd_upper
      |=> $stable(s.result) && $stable(s.res_ovf))
      else $error("result changed during upper read");

   a_ctrl_write: assert property (
      ce && s.dp_wr && s.dp_ctrl
      |=> s.continuous_select == $past(hwdata[`ADCRR_CONTINUOUS_SELECT_BIT]) && s.sel == $past(hwdata[3:0]))
      else $error("control write not taken");

   a_ctrl_hold: assert property (
      !(ce && s.dp_wr && s.dp_ctrl)
      |=> $stable(s.continuous_select) && $stable(s.sel))
      else $error("control fields changed without write");

   a_dp_capture: assert property (
      ce
      |=> s.dp_wr == $past(acc && hwrite))
      else $error("write data phase not tracked");

   a_pend_set: assert property (
      ce && done
      |=> s.pend)
      else $error("completion not remembered");

   a_pend_clear: assert property (
      ce && drain && !done
      |=> !s.pend)
      else $error("pending completion not consumed");

   a_pend_hold: assert property (
      !done && !drain
      |=> $stable(s.pend))
      else $error("pending completion changed without cause");

   a_mode_after_done: assert property (
      ce && $past(ce) && done
      |-> busy == $past(s.continuous_select))
      else $error("timer mode after completion wrong");

   a_idle_no_done: assert property (
      ce && !busy
      |=> !done)
      else $error("completion without a running conversion");

   a_busy_needs_start: assert property (
      $rose(busy)
      |-> $past(s.start))
      else $error("conversion began without start");

   a_buf_keeps: assert property (
      ce && core_valid && core_ready && !buf_valid
      |=> buf_valid)
      else $error("accepted sample not buffered");

   a_buf_fills: assert property (
      ce && core_valid && core_ready && buf_valid && !drain
      |=> !core_ready)
      else $error("second sample did not fill the buffer");

   a_buf_frees: assert property (
      ce && !core_ready && drain
      |=> core_ready)
      else $error("buffer not freed after drain");

endmodule

// ===== test/adc_result_readout_tb.sv
/*
   Self-checking bench for the converter result readout top level.
   Assumes adcrr_params.svh on the include path; the bench is the only
   bus master and stands in for the converter core.
*/
`timescale 1ns/100ps
`include "adcrr_params.svh"

module adc_result_readout_tb;

   localparam int INIT = 20;
   localparam int CONTINUOUS_SELECT = 4;

   logic              hclk;
   logic              hresetn;
   logic              ce;
   logic              hsel;
   logic [31:0]       haddr;
   logic [1:0]        htrans;
   logic              hwrite;
   logic [2:0]        hsize;
   logic [31:0]       hwdata;
   wire logic         hready;
   logic              hreadyout;
   logic              hresp;
   logic [31:0]       hrdata;
   logic              core_valid;
   logic [12:0]       core_data;
   logic              core_ovf;
   logic              core_ready;
   logic              conv_run;
   logic [3:0]        conv_input;
   logic              rd_ph;
   logic [31:0]       seed;
   logic [31:0]       qe[$];
   logic [31:0]       qm[$];
   string             qn[$];
   logic [12:0]       s;
   logic [12:0]       keep;
   logic              o;
   logic              keep_o;
   logic [3:0]        sel;
   int                n;
   int                bad_count;
   int                comparisons;

   assign hready = hreadyout;

   adcrr_top #(.INIT_CYC(INIT), .CONTINUOUS_SELECT_CYC(CONTINUOUS_SELECT)) dut
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .ce         (ce),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hwdata     (hwdata),
      .hready     (hready),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .hrdata     (hrdata),
      .core_valid (core_valid),
      .core_data  (core_data),
      .core_ovf   (core_ovf),
      .core_ready (core_ready),
      .conv_run   (conv_run),
      .conv_input (conv_input)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One single AHB-Lite transfer; the master waits for hready each phase.
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      rd_ph  <= !wr;
      do @(posedge hclk); while (hready !== 1'b1);
      rd_ph  <= 1'b0;
      hwdata <= ~wd;
   endtask

   task automatic rd(input string nm, input logic [11:0] idx, input logic [31:0] e,
                     input logic [31:0] m);
      qn.push_back(nm);
      qe.push_back(e & m);
      qm.push_back(m);
      bus(1'b0, idx, 32'h0);
   endtask

   task automatic rd_res(input logic [12:0] v, input logic f);
      rd("upper", `ADCRR_IDX_UPPER, {24'h0, v[12:5]}, 32'hffffffff);
      rd("lower", `ADCRR_IDX_LOWER, {24'h0, v[4:0], 2'b00, f}, 32'hfffffff9);
   endtask

   task automatic push(input logic [12:0] v, input logic f);
      core_valid <= 1'b1;
      core_data  <= v;
      core_ovf   <= f;
      do @(posedge hclk); while (!(core_valid === 1'b1 && core_ready === 1'b1));
      core_valid <= 1'b0;
      core_data  <= ~v;
      core_ovf   <= ~f;
      @(posedge hclk);
   endtask

   // Counts the cycles of one conversion, from the rise of conv_run.
   task automatic wait_conv(output int cyc);
      cyc = 0;
      repeat (10) if (conv_run !== 1'b1) @(posedge hclk);
      while (conv_run === 1'b1 && cyc < 200)
      begin
         @(posedge hclk);
         cyc++;
      end
   endtask

   // ****************************************************************
   // Read monitor: compares each read against the oldest note
   // ****************************************************************
   always @(posedge hclk)
      if (rd_ph === 1'b1 && hready === 1'b1)
      begin
         chk(qn.pop_front(), qe.pop_front(), hrdata & qm.pop_front());
         chk("hresp", 32'h0, {31'h0, hresp});
      end

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   initial
   begin
      #(100 * 4000);
      bad_count++;
      test_done();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      seed = 32'h8bd7;
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      rd_ph = 1'b0;
      core_valid = 1'b0;
      core_data = 13'h0;
      core_ovf = 1'b0;
      bad_count = 0;
      comparisons = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("conv_run", 32'h0, {31'h0, conv_run});
      rd("control", `ADCRR_IDX_CTRL, 32'h0, 32'hffffffff);
      $display("test reset done");

      // Single shot on a plain input and on the temperature sensor.
      for (int k = 0; k < 2; k++)
      begin
         sel = k ? 4'he : 4'h3;
         s = 13'(xs());
         push(s, 1'b0);
         bus(1'b1, `ADCRR_IDX_CTRL, {24'h0, 4'h8, sel});
         wait_conv(n);
         chk("conv_cycles", INIT * (k + 1), n);
         chk("conv_input", {28'h0, sel}, {28'h0, conv_input});
         rd("control", `ADCRR_IDX_CTRL, {28'h0, sel}, 32'hffffffff);
         rd_res(s, 1'b0);
      end
      $display("test single_shot done");

      // Snapshot survives a later conversion until the next upper read.
      keep = 13'(xs());
      push(keep, 1'b1);
      bus(1'b1, `ADCRR_IDX_CTRL, 32'h80);
      wait_conv(n);
      rd("control", `ADCRR_IDX_CTRL, 32'h0, 32'hffffffff);
      rd("upper", `ADCRR_IDX_UPPER, {24'h0, keep[12:5]}, 32'hffffffff);
      s = 13'(xs());
      push(s, 1'b0);
      bus(1'b1, `ADCRR_IDX_CTRL, 32'h80);
      wait_conv(n);
      rd("lower_held", `ADCRR_IDX_LOWER, {24'h0, keep[4:0], 3'b001}, 32'hfffffff9);
      rd_res(s, 1'b0);
      $display("test snapshot done");

      // Writes to the result registers change nothing; unmapped reads 0.
      bus(1'b1, `ADCRR_IDX_UPPER, 32'hffffffff);
      bus(1'b1, `ADCRR_IDX_LOWER, 32'hffffffff);
      rd_res(s, 1'b0);
      rd("unmapped", 12'h100, 32'h0, 32'hffffffff);
      $display("test read_only done");

      // Continuous mode: buffer fills, refuses, and the newest sample wins.
      bus(1'b1, `ADCRR_IDX_CTRL, 32'h90);
      push(13'(xs()), 1'b0);
      push(13'(xs()), 1'b1);
      @(posedge hclk);
      chk("core_ready_full", 32'h0, {31'h0, core_ready});
      push(13'(xs()), 1'b0);
      keep = 13'(xs());
      keep_o = keep[7];
      push(keep, keep_o);
      repeat (INIT + 4 * CONTINUOUS_SELECT) @(posedge hclk);
      bus(1'b1, `ADCRR_IDX_CTRL, 32'h00);
      repeat (3 * CONTINUOUS_SELECT) @(posedge hclk);
      chk("conv_run_stop", 32'h0, {31'h0, conv_run});
      rd("control", `ADCRR_IDX_CTRL, 32'h0, 32'hffffffff);
      rd_res(keep, keep_o);
      $display("test continuous done");
      test_done();
   end

endmodule
